/* design/acc_regs.sv */
/*
  APB register slice of a three-channel delta-sigma converter: current
  detect threshold, high-pass coefficient, channel 0 configuration and
  channel 0 offset/gain calibration with a calibration datapath.
  Assumes: pclk at 50 MHz, APB master per the protocol, conversion
  samples arriving synchronous to pclk as signed 24-bit words.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "acc_map.svh"

// Behaviour
// - threshold low byte lives in bits 15:8 of threshold-low, RW, resets zero
// - threshold upper sixteen bits live in threshold-high, forming full threshold
// - high-pass code in bits 3:0; code zero switches the filter off
// - nonzero code n gives coefficient one over two to the n+1
// - channel 0 config bits 15:6 are a signed phase delay
// - channel 0 bit 2 set disables high-pass for that channel only
// - channel 0 bits 1:0 select pins, shorted, positive or negative test
// - offset bits 23:8 come from the offset-high register
// - offset bits 7:0 from offset-low 15:8; its low byte reads zero
// - gain bits 23:8 from gain-high, which resets to 8000h
// - gain bits 7:0 from gain-low 15:8; its low byte reads zero
module acc_regs #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // conversion samples in
  input wire logic sample_valid,
  input wire logic signed [23:0] sample_data,
  // decoded controls to the core
  output logic [23:0] detect_threshold,
  output acc_pkg::acc_hp_s highpass,
  output acc_pkg::acc_ch0_s ch0_config,
  output logic [23:0] ch0_offset,
  output logic [23:0] ch0_gain,
  output logic [15:0] ch1_config,
  // calibrated samples out
  output logic cal_valid,
  output logic signed [23:0] cal_data
);

  acc_pkg::acc_state_s q;
  acc_pkg::acc_state_s d;

  // merge writable bits of a write, honouring the two low byte strobes
  function automatic logic [15:0] acc_upd(
    input logic [15:0] old,
    input logic [15:0] wmask,
    input logic [15:0] wdata,
    input logic [1:0] strb
  );
    logic [15:0] m;
    m = wmask & {{8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (wdata & m);
  endfunction : acc_upd

  // next-state logic for the whole slice
  always_comb
  begin
    logic [5:0] idx;
    logic hit;
    logic [15:0] rd;
    logic wr;
    logic signed [24:0] sum;
    logic signed [49:0] prod;
    logic signed [26:0] scaled;
    idx = paddr[7:2];
    hit = 1'b0;
    rd = `ACC_RST_ZERO;
    wr = 1'b0;
    sum = '0;
    prod = '0;
    scaled = '0;
    d = q;

    // address decode; read-only bits already sit at zero in storage
    unique case (idx)
      `ACC_IDX_THR_HI:
      begin
        hit = 1'b1;
        rd = q.thr_hi;
      end
      `ACC_IDX_THR_LO:
      begin
        hit = 1'b1;
        rd = q.thr_lo;
      end
      `ACC_IDX_CHANNEL0_CONFIG:
      begin
        hit = 1'b1;
        rd = q.channel0_config;
      end
      `ACC_IDX_OCAL_HI:
      begin
        hit = 1'b1;
        rd = q.ocal_hi;
      end
      `ACC_IDX_OCAL_LO:
      begin
        hit = 1'b1;
        rd = q.ocal_lo;
      end
      `ACC_IDX_GCAL_HI:
      begin
        hit = 1'b1;
        rd = q.gcal_hi;
      end
      `ACC_IDX_GCAL_LO:
      begin
        hit = 1'b1;
        rd = q.gcal_lo;
      end
      `ACC_IDX_CHANNEL1_CONFIG:
      begin
        hit = 1'b1;
        rd = q.channel1_config;
      end
      default:
      begin
        hit = 1'b0;
        rd = `ACC_RST_ZERO;
      end
    endcase
    // misaligned addresses are treated as unmapped
    if (paddr[1:0] != `ACC_ALIGN_OK)
    begin
      hit = 1'b0;
      rd = `ACC_RST_ZERO;
    end

    // one wait state: pready raised in the second access cycle
    d.pready = 1'b0;
    if (psel && penable && !q.pready)
    begin
      d.pready = 1'b1;
      d.pslverr = !hit;
      d.prdata = pwrite ? 32'h0000_0000 : {16'h0000, rd};
    end

    // writes take effect only at the completing edge
    wr = psel && penable && q.pready && pwrite && hit;
    if (wr)
    begin
      unique case (idx)
        `ACC_IDX_THR_HI:
          d.thr_hi = acc_upd(q.thr_hi, `ACC_WM_FULL, pwdata[15:0], pstrb[1:0]);
        `ACC_IDX_THR_LO:
          d.thr_lo = acc_upd(q.thr_lo, `ACC_WM_THR_LO, pwdata[15:0], pstrb[1:0]);
        // reserved bits 5:3 are held at zero whatever is written
        `ACC_IDX_CHANNEL0_CONFIG:
          d.channel0_config = acc_upd(q.channel0_config, `ACC_WM_CFG, pwdata[15:0], pstrb[1:0]);
        `ACC_IDX_OCAL_HI:
          d.ocal_hi = acc_upd(q.ocal_hi, `ACC_WM_FULL, pwdata[15:0], pstrb[1:0]);
        `ACC_IDX_OCAL_LO:
          d.ocal_lo = acc_upd(q.ocal_lo, `ACC_WM_CAL_LO, pwdata[15:0], pstrb[1:0]);
        `ACC_IDX_GCAL_HI:
          d.gcal_hi = acc_upd(q.gcal_hi, `ACC_WM_FULL, pwdata[15:0], pstrb[1:0]);
        `ACC_IDX_GCAL_LO:
          d.gcal_lo = acc_upd(q.gcal_lo, `ACC_WM_CAL_LO, pwdata[15:0], pstrb[1:0]);
        `ACC_IDX_CHANNEL1_CONFIG:
          d.channel1_config = acc_upd(q.channel1_config, `ACC_WM_CFG, pwdata[15:0], pstrb[1:0]);
        default:
          d.channel1_config = q.channel1_config;
      endcase
    end

    // decoded controls follow the new register values in the same edge
    d.threshold = {d.thr_hi, d.thr_lo[15:8]};
    d.hp.enable = (d.thr_lo[3:0] != `ACC_HP_CODE_OFF);
    d.hp.shift = {1'b0, d.thr_lo[3:0]} + `ACC_HP_SHIFT_BIAS;
    d.ch0.phase = $signed(d.channel0_config[15:6]);
    d.ch0.hp_off = d.channel0_config[2];
    d.ch0.input_sel = acc_pkg::acc_mux_e'(d.channel0_config[1:0]);
    d.hp.ch0_on = d.hp.enable && !d.channel0_config[2];
    d.offset = {d.ocal_hi, d.ocal_lo[15:8]};
    d.gain = {d.gcal_hi, d.gcal_lo[15:8]};

    // offset first, then gain as an unsigned 1.23 fraction; saturate
    sum = 25'(sample_data) + 25'($signed(q.offset));
    prod = sum * $signed({1'b0, q.gain});
    scaled = 27'(prod >>> `ACC_GAIN_FRAC);
    d.cal_valid = sample_valid;
    if (sample_valid)
    begin
      if (scaled > 27'sh07F_FFFF)
        d.cal_data = 24'h7F_FFFF;
      else if (scaled < -27'sh080_0000)
        d.cal_data = 24'h80_0000;
      else
        d.cal_data = scaled[23:0];
    end
  end

  // state register; gain-high, the decoded gain and the high-pass shift are the non-zero resets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.gcal_hi <= `ACC_RST_GAIN_HI;
      q.gain <= {`ACC_RST_GAIN_HI, 8'h00};
      q.hp.shift <= `ACC_HP_SHIFT_BIAS;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign detect_threshold = q.threshold;
  assign highpass = q.hp;
  assign ch0_config = q.ch0;
  assign ch0_offset = q.offset;
  assign ch0_gain = q.gain;
  assign ch1_config = q.channel1_config;
  assign cal_valid = q.cal_valid;
  assign cal_data = q.cal_data;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a completed write to one register index with both low strobes
  sequence s_wr(logic [5:0] i);
    psel && penable && pready && pwrite && paddr[7:2] == i
      && paddr[1:0] == `ACC_ALIGN_OK && pstrb[1:0] == 2'b11;
  endsequence

  // a read whose data is being presented at completion
  sequence s_rd(logic [5:0] i);
    psel && penable && pready && !pwrite && paddr[7:2] == i
      && paddr[1:0] == `ACC_ALIGN_OK;
  endsequence

  // access phase answers after exactly one wait cycle
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");

  property p_thr_lo;
    s_wr(`ACC_IDX_THR_LO) |=> detect_threshold[7:0] == $past(pwdata[15:8]);
  endproperty
  a_thr_lo: assert property (p_thr_lo) else $error("threshold low byte wrong");

  property p_thr_hi;
    s_wr(`ACC_IDX_THR_HI) |=> detect_threshold[23:8] == $past(pwdata[15:0]);
  endproperty
  a_thr_hi: assert property (p_thr_hi) else $error("threshold high word wrong");

  property p_hp_off;
    s_wr(`ACC_IDX_THR_LO) ##0 (pwdata[3:0] == `ACC_HP_CODE_OFF)
      |=> !highpass.enable && !highpass.ch0_on;
  endproperty
  a_hp_off: assert property (p_hp_off) else $error("high-pass on with code zero");

  property p_hp_coef;
    s_wr(`ACC_IDX_THR_LO) ##0 (pwdata[3:0] != `ACC_HP_CODE_OFF)
      |=> highpass.enable && highpass.shift == 5'($past(pwdata[3:0])) + `ACC_HP_SHIFT_BIAS;
  endproperty
  a_hp_coef: assert property (p_hp_coef) else $error("coefficient shift wrong");

  property p_phase;
    s_wr(`ACC_IDX_CHANNEL0_CONFIG) |=> ch0_config.phase == $signed($past(pwdata[15:6]));
  endproperty
  a_phase: assert property (p_phase) else $error("phase delay wrong");

  property p_ch0_hp;
    highpass.ch0_on == (highpass.enable && !ch0_config.hp_off);
  endproperty
  a_ch0_hp: assert property (p_ch0_hp) else $error("channel high-pass gate wrong");

  property p_mux;
    s_wr(`ACC_IDX_CHANNEL0_CONFIG) |=> ch0_config.input_sel == $past(pwdata[1:0]);
  endproperty
  a_mux: assert property (p_mux) else $error("input select wrong");

  property p_ocal;
    s_wr(`ACC_IDX_OCAL_HI) |=> ch0_offset[23:8] == $past(pwdata[15:0]);
  endproperty
  a_ocal: assert property (p_ocal) else $error("offset high word wrong");

  property p_ocal_lo;
    s_rd(`ACC_IDX_OCAL_LO) |-> prdata[7:0] == 8'h00 && prdata[15:8] == ch0_offset[7:0];
  endproperty
  a_ocal_lo: assert property (p_ocal_lo) else $error("offset low read wrong");

  property p_gcal_hi;
    s_rd(`ACC_IDX_GCAL_HI) |-> prdata[15:0] == ch0_gain[23:8];
  endproperty
  a_gcal_hi: assert property (p_gcal_hi) else $error("gain high read wrong");

  property p_gcal_lo;
    s_rd(`ACC_IDX_GCAL_LO) |-> prdata[7:0] == 8'h00 && prdata[15:8] == ch0_gain[7:0];
  endproperty
  a_gcal_lo: assert property (p_gcal_lo) else $error("gain low read wrong");

  property p_unity;
    sample_valid && ch0_gain == 24'h80_0000 && ch0_offset == 24'h00_0000
      |=> cal_valid && cal_data == $past(sample_data);
  endproperty
  a_unity: assert property (p_unity) else $error("unity calibration altered sample");

  // bit 2 set turns the filter off for channel 0 whatever the global code says
  property p_ch0_dis;
    s_wr(`ACC_IDX_CHANNEL0_CONFIG) ##0 pwdata[2] |=> !highpass.ch0_on && ch0_config.hp_off;
  endproperty
  a_ch0_dis: assert property (p_ch0_dis) else $error("channel high-pass not disabled");

  property p_thr_lo_rd;
    s_rd(`ACC_IDX_THR_LO) |-> prdata[7:4] == 4'h0 && prdata[15:8] == detect_threshold[7:0];
  endproperty
  a_thr_lo_rd: assert property (p_thr_lo_rd) else $error("threshold low read wrong");

  property p_cfg_rd;
    s_rd(`ACC_IDX_CHANNEL0_CONFIG) |-> prdata[5:3] == 3'b000 && prdata[15:6] == ch0_config.phase;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("channel config read wrong");

  property p_ocal_lo_wr;
    s_wr(`ACC_IDX_OCAL_LO) |=> ch0_offset[7:0] == $past(pwdata[15:8]);
  endproperty
  a_ocal_lo_wr: assert property (p_ocal_lo_wr) else $error("offset low byte wrong");

  property p_gcal_wr;
    s_wr(`ACC_IDX_GCAL_HI) |=> ch0_gain[23:8] == $past(pwdata[15:0]);
  endproperty
  a_gcal_wr: assert property (p_gcal_wr) else $error("gain high word wrong");

  property p_gcal_lo_wr;
    s_wr(`ACC_IDX_GCAL_LO) |=> ch0_gain[7:0] == $past(pwdata[15:8]);
  endproperty
  a_gcal_lo_wr: assert property (p_gcal_lo_wr) else $error("gain low byte wrong");

  // every sample yields exactly one result strobe, one cycle later
  property p_cal_pulse;
    cal_valid == $past(sample_valid);
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("result strobe misplaced");

endmodule : acc_regs

/* design/acc_map.svh */
/*
  Register indices, write masks, reset values and datapath constants
  for the channel calibration and configuration register slice.
  Assumes: included by its bare name; byte address is index times four.
*/
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// register indices (byte address = index * 4)
`define ACC_IDX_THR_HI 6'h07
`define ACC_IDX_THR_LO 6'h08
`define ACC_IDX_CHANNEL0_CONFIG 6'h09
`define ACC_IDX_OCAL_HI 6'h0A
`define ACC_IDX_OCAL_LO 6'h0B
`define ACC_IDX_GCAL_HI 6'h0C
`define ACC_IDX_GCAL_LO 6'h0D
`define ACC_IDX_CHANNEL1_CONFIG 6'h0E

// reset values
`define ACC_RST_ZERO 16'h0000
`define ACC_RST_GAIN_HI 16'h8000

// writable-bit masks; clear bits are read-only zero
`define ACC_WM_FULL 16'hFFFF
`define ACC_WM_THR_LO 16'hFF0F
`define ACC_WM_CFG 16'hFFC7
`define ACC_WM_CAL_LO 16'hFF00

// field helpers
`define ACC_HP_CODE_OFF 4'h0
`define ACC_HP_SHIFT_BIAS 5'h01
`define ACC_GAIN_FRAC 23
`define ACC_ALIGN_OK 2'h0

`endif

/* design/acc_pkg.sv */
/*
  Types for the channel calibration and configuration register slice.
  Assumes: constants come from acc_map.svh; users write acc_pkg::name.
*/
package acc_pkg;

  // channel input multiplexer setting
  typedef enum logic [1:0] {
    ACC_IN_PINS,
    ACC_IN_SHORTED,
    ACC_IN_TEST_POS,
    ACC_IN_TEST_NEG
  } acc_mux_e;

  // decoded channel 0 configuration
  typedef struct packed {
    logic signed [9:0] phase;
    logic hp_off;
    acc_mux_e input_sel;
  } acc_ch0_s;

  // high-pass control: coefficient is 2**-shift when enabled
  typedef struct packed {
    logic enable;
    logic [4:0] shift;
    logic ch0_on;
  } acc_hp_s;

  // whole state of the register slice
  typedef struct packed {
    logic [15:0] thr_hi;
    logic [15:0] thr_lo;
    logic [15:0] channel0_config;
    logic [15:0] ocal_hi;
    logic [15:0] ocal_lo;
    logic [15:0] gcal_hi;
    logic [15:0] gcal_lo;
    logic [15:0] channel1_config;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [23:0] threshold;
    acc_hp_s hp;
    acc_ch0_s ch0;
    logic [23:0] offset;
    logic [23:0] gain;
    logic cal_valid;
    logic [23:0] cal_data;
  } acc_state_s;

endpackage : acc_pkg

/* bench/acc_regs_tb.sv */
/*
  Self-checking testbench for acc_regs: register reset values and access
  kinds over APB, decoded controls, refused accesses, calibration path.
  Assumes acc_pkg is compiled first and acc_map.svh is on the include path.
*/
`timescale 1ns/1ps
`include "acc_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module acc_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic sample_valid = 1'b0;
  logic signed [23:0] sample_data = 24'h000000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [23:0] detect_threshold;
  acc_pkg::acc_hp_s highpass;
  acc_pkg::acc_ch0_s ch0_config;
  logic [23:0] ch0_offset;
  logic [23:0] ch0_gain;
  logic [15:0] ch1_config;
  logic cal_valid;
  logic signed [23:0] cal_data;
  int n_errors = 0;
  int n_checks = 0;
  logic [15:0] lfsr_q = 16'h7007;
  logic [15:0] sh [7:14];

  acc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_data(sample_data), .detect_threshold(detect_threshold),
    .highpass(highpass), .ch0_config(ch0_config), .ch0_offset(ch0_offset),
    .ch0_gain(ch0_gain), .ch1_config(ch1_config), .cal_valid(cal_valid), .cal_data(cal_data));

  // 50 mhz clock
  always #10 pclk = ~pclk;

  // fixed-seed lfsr keeps every run repeatable
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
    return lfsr_q;
  endfunction : rnd

  // bits that hold data; the rest read back as zero
  function automatic logic [15:0] rmask(input int idx);
    case (idx)
      8: return 16'hFF0F;
      9, 14: return 16'hFFC7;
      11, 13: return 16'hFF00;
      default: return 16'hFFFF;
    endcase
  endfunction : rmask

  // offset first, then gain with 800000h as one, saturated to 24 bits
  function automatic logic signed [23:0] cal_exp(input logic signed [23:0] s,
    input logic [23:0] off, input logic [23:0] g);
    longint p;
    p = (longint'(s) + longint'($signed(off))) * longint'({40'h0000000000, g});
    p = p >>> 23;
    if (p > 8388607)
      p = 8388607;
    if (p < -8388608)
      p = -8388608;
    return p[23:0];
  endfunction : cal_exp

  // one apb transfer; waits for pready, which only the watchdog cuts short
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {rnd(), d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // write a mapped register and track what it should now hold
  task automatic wreg(input int idx, input logic [15:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, {idx[5:0], 2'b00}, d, rd, e);
    sh[idx] = d & rmask(idx);
  endtask : wreg

  task automatic rreg(input int idx);
    logic [31:0] rd;
    logic e;
    apb(1'b0, {idx[5:0], 2'b00}, 16'h0000, rd, e);
    `CHK(rd, {16'h0000, sh[idx]})
    `CHK(e, 1'b0)
  endtask : rreg

  // decoded controls against the tracked register contents
  task automatic chk_dec();
    logic [3:0] c;
    logic [6:0] hp;
    c = sh[8][3:0];
    hp = {c != 4'h0, {1'b0, c} + 5'h01, (c != 4'h0) & ~sh[9][2]};
    `CHK(detect_threshold, {sh[7], sh[8][15:8]})
    `CHK(highpass, hp)
    `CHK(ch0_config, {sh[9][15:6], sh[9][2], sh[9][1:0]})
    `CHK(ch0_offset, {sh[10], sh[11][15:8]})
    `CHK(ch0_gain, {sh[12], sh[13][15:8]})
    `CHK(ch1_config, sh[14])
  endtask : chk_dec

  // back-to-back samples; each result is looked at in its one valid cycle
  // unity: zero offset and gain of exactly one, so results equal samples
  task automatic cal_run(input bit unity);
    logic signed [23:0] s [6];
    logic [23:0] off;
    logic [23:0] g;
    wreg(10, unity ? 16'h0000 : rnd());
    wreg(11, unity ? 16'h0000 : rnd());
    wreg(12, unity ? 16'h8000 : rnd());
    wreg(13, unity ? 16'h0000 : rnd());
    off = {sh[10], sh[11][15:8]};
    g = {sh[12], sh[13][15:8]};
    foreach (s[i])
    begin
      s[i][23:8] = rnd();
      s[i][7:0] = lfsr_q[11:4];
    end
    s[0] = 24'h7FFFFF;
    s[1] = 24'h800000;
    for (int i = 0; i <= 6; i++)
    begin
      @(posedge pclk);
      sample_valid <= (i < 6);
      sample_data <= s[i % 6];
      @(negedge pclk);
      if (i > 0)
      begin
        `CHK(cal_valid, 1'b1)
        `CHK(cal_data, cal_exp(s[i - 1], off, g))
      end
    end
    @(negedge pclk);
    `CHK(cal_valid, 1'b0)
    `CHK(cal_data, cal_exp(s[5], off, g))
    @(posedge pclk);
  endtask : cal_run

  task finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    logic [15:0] d;
    logic [31:0] rd;
    logic e;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (sh[i]) sh[i] = 16'h0000;
    sh[12] = 16'h8000;
    for (int i = 7; i < 15; i++) rreg(i);
    chk_dec();
    $display("test reset done");
    repeat (4)
    begin
      for (int i = 7; i < 15; i++)
      begin
        d = rnd();
        if (i == 9 || i == 14)
          d[5:3] = 3'b000;
        wreg(i, d);
        chk_dec();
      end
      for (int i = 7; i < 15; i++) rreg(i);
    end
    $display("test random access done");
    for (int c = 0; c < 64; c++)
    begin
      d = rnd();
      wreg(8, {d[15:4], c[3:0]});
      wreg(9, {d[15:6], 3'b000, c[4] ^ c[0], c[5:4]});
      chk_dec();
    end
    rreg(8);
    $display("test codes done");
    apb(1'b0, 8'h18, 16'h0000, rd, e);
    `CHK(e, 1'b1)
    `CHK(rd, 32'h00000000)
    apb(1'b1, 8'h21, 16'hFFFF, rd, e);
    `CHK(e, 1'b1)
    apb(1'b1, 8'hFC, 16'hFFFF, rd, e);
    `CHK(e, 1'b1)
    chk_dec();
    $display("test refused done");
    // byte strobes: only the lane whose strobe is set may change
    d = rnd();
    pstrb <= 4'hE;
    apb(1'b1, 8'h28, d, rd, e);
    sh[10][15:8] = d[15:8];
    pstrb <= 4'hD;
    apb(1'b1, 8'h1C, d, rd, e);
    sh[7][7:0] = d[7:0];
    pstrb <= 4'hF;
    chk_dec();
    rreg(10);
    rreg(7);
    $display("test strobes done");
    cal_run(1'b1);
    cal_run(1'b0);
    cal_run(1'b0);
    $display("test calibration done");
    finish_test();
  end

  // watchdog well past the thousand or so cycles the tests need
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule : acc_regs_tb
